// ### rtl/port_cfg_defines.svh
// How it works
// - vga wide decode select at bridge control bit 4, effective only with route enable.
// - select clear decodes vga io on 10 bits with aliases; set decodes 16 bits.
// - writing one to bridge control bit 6 pulses a secondary bus reset, or an upstream reset on the upstream port.
// - capability identifier bits 7:0 read-only, always 0x10.
// - next capability pointer bits 15:8 lockable, resets to 0xc0.
// - capability version bits 19:16 lockable, resets to 0x1 in every mode.
// - port type bits 23:20 read-only: 0x5 upstream, 0x6 downstream.
// - slot bit 24 lockable; must stay cleared on the upstream port.
// - message vector number bits 29:25 read-only zero.
// - traffic class routing bit 30 lockable; resets 1, or 0 in 1.1 mode.
// - max payload bits 2:0 lockable, resets to 0x4 meaning 2048 bytes.
// - phantom function support bits 4:3 read-only zero.
// - extended tag bit 5 lockable, resets to 0x1.
// - endpoint low-power exit latency bits 8:6 read-only zero.
// - vga route enable at bridge control bit 3 gates vga forwarding.
`ifndef PORT_CFG_DEFINES_SVH
`define PORT_CFG_DEFINES_SVH
`define CAP_HDR_ADDR      8'h40
`define DEV_CAP_ADDR      8'h44
`define BRIDGE_CTL_ADDR   8'h3c
`define LOCK_CTL_ADDR     8'h80
`define BC_VGA_EN_BIT     19
`define BC_VGA16_BIT      20
`define BC_SECONDARY_BUS_RESET_TRIGGER_BIT     22
`define CAP_ID_VAL        8'h10
`define NXT_PTR_RST       8'hc0
`define CAP_VER_RST       4'h1
`define TYPE_UP           4'h5
`define TYPE_DOWN         4'h6
`define TCS_RST           1'b1
`define TCS_RST_V11       1'b0
`define MAX_PAYLOAD_SUPPORT_RST      3'h4
`define EXTENDED_TAG_SUPPORT_RST          1'b1
`define VGA_MEM_LO        16'h03b0
`define VGA_MEM_HI        16'h03bb
`define VGA_IO2_LO        16'h03c0
`define VGA_IO2_HI        16'h03df
`endif

// ### rtl/port_cfg_pkg.sv
package port_cfg_pkg;
  typedef logic [31:0] cfg_word_t;
  typedef logic [3:0]  cfg_sel_t;
endpackage

// ### rtl/wb_if.sv
`timescale 1ns/1ps
`default_nettype none
// classic wishbone request and answer between top and slave
interface wb_if;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_w;
  logic        take;
  modport top (output cyc, stb, we, adr, sel, dat_w, input take);
  modport slv (input cyc, stb, we, adr, sel, dat_w, output take);
endinterface
`default_nettype wire

// ### rtl/wb_ack_gen.sv
`timescale 1ns/1ps
`default_nettype none
// one-cycle ack per request; ack drops in the cycle after it was given
module wb_ack_gen
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  wb_if.slv         bus,
  output var  logic ack_o
);
  logic ack_reg;
  logic ack_next;

  // take only when no ack is pending, so a held request is taken every second cycle
  assign ack_next = bus.cyc & bus.stb & ~ack_reg;
  assign bus.take = ack_next;
  assign ack_o    = ack_reg;

  // ack flop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= ack_next;
  end
endmodule // wb_ack_gen
`default_nettype wire

// ### rtl/switch_port_config_capability_regs.sv
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "port_cfg_defines.svh"
module switch_port_config_capability_regs
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 upstream_port_i,
  input  wire logic                 mode_v11_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire port_cfg_pkg::cfg_sel_t  wb_sel_i,
  input  wire port_cfg_pkg::cfg_word_t wb_dat_i,
  output var  port_cfg_pkg::cfg_word_t wb_dat_o,
  output var  logic                 wb_ack_o,
  input  wire logic                 io_req_i,
  input  wire logic [15:0]          io_addr_i,
  output var  logic                 vga_forward_o,
  output var  logic                 secondary_reset_o,
  output var  logic                 upstream_reset_o
);
  import port_cfg_pkg::*;

  wb_if bus ();

  logic        upstream_s1_reg;
  logic        upstream_s2_reg;
  logic        v11_s1_reg;
  logic        v11_s2_reg;
  logic        rst_d_reg;
  logic        vga_en_reg;
  logic        vga16_reg;
  logic        lock_reg;
  logic [7:0]  nxt_ptr_reg;
  logic [3:0]  cap_ver_reg;
  logic        slot_reg;
  logic        tcs_reg;
  logic [2:0]  max_payload_support_reg;
  logic        extended_tag_support_reg;
  logic        sec_rst_reg;
  logic        up_rst_reg;
  logic        vga_fwd_reg;
  cfg_word_t   dat_o_reg;

  // straps come from pins: two flops before use; kept out of reset so they have
  // settled by the time reset releases and the mode dependent defaults load
  always_ff @(posedge clk_i)
  begin
    upstream_s1_reg <= upstream_port_i;
    upstream_s2_reg <= upstream_s1_reg;
  end

  // protocol mode strap, same two-flop path
  always_ff @(posedge clk_i)
  begin
    v11_s1_reg <= mode_v11_i;
    v11_s2_reg <= v11_s1_reg;
  end

  // bus wiring into the interface
  assign bus.cyc   = wb_cyc_i;
  assign bus.stb   = wb_stb_i;
  assign bus.we    = wb_we_i;
  assign bus.adr   = wb_adr_i;
  assign bus.sel   = wb_sel_i;
  assign bus.dat_w = wb_dat_i;

  wb_ack_gen u_ack
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (bus),
    .ack_o (wb_ack_o)
  );

  // address decode
  logic hit_cap;
  logic hit_dev;
  logic hit_bc;
  logic hit_lock;
  logic wr;
  logic rd_take;
  logic wr_unlocked;
  assign hit_cap     = (bus.adr == `CAP_HDR_ADDR);
  assign hit_dev     = (bus.adr == `DEV_CAP_ADDR);
  assign hit_bc      = (bus.adr == `BRIDGE_CTL_ADDR);
  assign hit_lock    = (bus.adr == `LOCK_CTL_ADDR);
  assign wr          = bus.take & bus.we;
  assign rd_take     = bus.take & ~bus.we;
  // lockable fields accept writes only while the lock is open
  assign wr_unlocked = wr & ~lock_reg;

  // per-field write strobes; byte lanes gate each field, other lanes keep their value
  logic wr_next_ptr;
  logic wr_cap_ver;
  logic wr_slot_tcs;
  logic wr_dev_cap;
  logic wr_bridge;
  logic wr_lock;
  // lockable write strobes
  assign wr_next_ptr = wr_unlocked & hit_cap & bus.sel[1];
  assign wr_cap_ver  = wr_unlocked & hit_cap & bus.sel[2];
  assign wr_slot_tcs = wr_unlocked & hit_cap & bus.sel[3];
  assign wr_dev_cap  = wr_unlocked & hit_dev & bus.sel[0];
  // bridge control and the lock itself are never locked
  assign wr_bridge   = wr & hit_bc & bus.sel[2];
  assign wr_lock     = wr & hit_lock & bus.sel[0];

  // reset values that depend on the protocol mode strap
  logic tcs_rst_val;
  assign tcs_rst_val = v11_s2_reg ? `TCS_RST_V11 : `TCS_RST;

  // 10-bit decode ignores bits 15:10, so aliases in each 1 KB block match;
  // 16-bit decode matches the two windows only
  logic [15:0] vga_addr;
  logic        vga_mem_hit;
  logic        vga_io_hit;
  logic        vga_hit;
  assign vga_addr    = vga16_reg ? io_addr_i : {6'h00, io_addr_i[9:0]};
  assign vga_mem_hit = (vga_addr >= `VGA_MEM_LO) && (vga_addr <= `VGA_MEM_HI);
  assign vga_io_hit  = (vga_addr >= `VGA_IO2_LO) && (vga_addr <= `VGA_IO2_HI);
  assign vga_hit     = vga_mem_hit | vga_io_hit;

  // read words; reserved and read-only zero fields are zero, cap id is 0x10
  cfg_word_t  cap_word;
  cfg_word_t  dev_word;
  cfg_word_t  bc_word;
  cfg_word_t  rd_word;
  logic [3:0] port_type;
  assign port_type = upstream_s2_reg ? `TYPE_UP : `TYPE_DOWN;
  // capability header, most significant field first
  assign cap_word  = {1'b0,
                      tcs_reg,
                      5'h00,
                      slot_reg,
                      port_type,
                      cap_ver_reg,
                      nxt_ptr_reg,
                      `CAP_ID_VAL};
  // device capabilities: phantom functions and exit latency do not apply here
  assign dev_word  = {23'h000000,
                      3'h0,
                      extended_tag_support_reg,
                      2'h0,
                      max_payload_support_reg};
  // bridge control upper half sits in lanes 2 and 3; the trigger bit reads zero
  assign bc_word   = {9'h000,
                      1'b0,
                      1'b0,
                      vga16_reg,
                      vga_en_reg,
                      19'h00000};
  // read select; unmapped addresses read zero
  assign rd_word   = hit_cap  ? cap_word :
                     hit_dev  ? dev_word :
                     hit_bc   ? bc_word  :
                     hit_lock ? {31'h00000000, lock_reg} : 32'h00000000;

  // read data latched with the ack, unmapped reads return zero;
  // it holds until the next read, a write leaves it alone
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o_reg <= 32'h00000000;
    else if (rd_take)
      dat_o_reg <= rd_word;
  end
  assign wb_dat_o = dat_o_reg;

  // lock register: software closes it after configuring
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lock_reg <= 1'b0;
    else if (wr_lock)
      lock_reg <= bus.dat_w[0];
  end

  // vga route enable gates all vga forwarding
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      vga_en_reg <= 1'b0;
    else if (wr_bridge)
      vga_en_reg <= bus.dat_w[`BC_VGA_EN_BIT];
  end

  // wide decode select only matters while routing is enabled
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      vga16_reg <= 1'b0;
    else if (wr_bridge)
      vga16_reg <= bus.dat_w[`BC_VGA16_BIT];
  end

  // marks the first edge after reset release, when the mode default loads
  always_ff @(posedge clk_i)
  begin
    rst_d_reg <= rst_i;
  end

  // next capability pointer, lockable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      nxt_ptr_reg <= `NXT_PTR_RST;
    else if (wr_next_ptr)
      nxt_ptr_reg <= bus.dat_w[15:8];
  end

  // capability version, lockable; one reset value in every mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cap_ver_reg <= `CAP_VER_RST;
    else if (wr_cap_ver)
      cap_ver_reg <= bus.dat_w[19:16];
  end

  // slot present, lockable; an upstream port has no slot, so a one is dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      slot_reg <= 1'b0;
    else if (wr_slot_tcs)
      slot_reg <= bus.dat_w[24] & ~upstream_s2_reg;
  end

  // traffic class routing, lockable; its default needs the settled mode strap,
  // so it loads one edge after reset instead of inside it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tcs_reg <= `TCS_RST;
    else if (rst_d_reg)
      tcs_reg <= tcs_rst_val;
    else if (wr_slot_tcs)
      tcs_reg <= bus.dat_w[30];
  end

  // maximum payload size, lockable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      max_payload_support_reg <= `MAX_PAYLOAD_SUPPORT_RST;
    else if (wr_dev_cap)
      max_payload_support_reg <= bus.dat_w[2:0];
  end

  // extended tag, lockable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      extended_tag_support_reg <= `EXTENDED_TAG_SUPPORT_RST;
    else if (wr_dev_cap)
      extended_tag_support_reg <= bus.dat_w[5];
  end

  // reset trigger: one-cycle pulse per write of one; the bit is not kept, so a
  // stale bit can never start a second reset
  logic secondary_bus_reset_trigger_wr;
  logic sec_rst_next;
  logic up_rst_next;
  assign secondary_bus_reset_trigger_wr    = wr_bridge & bus.dat_w[`BC_SECONDARY_BUS_RESET_TRIGGER_BIT];
  assign sec_rst_next = secondary_bus_reset_trigger_wr & ~upstream_s2_reg;
  assign up_rst_next  = secondary_bus_reset_trigger_wr & upstream_s2_reg;

  // downstream port: secondary bus reset pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sec_rst_reg <= 1'b0;
    else
      sec_rst_reg <= sec_rst_next;
  end

  // upstream port: upstream form of the same reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      up_rst_reg <= 1'b0;
    else
      up_rst_reg <= up_rst_next;
  end
  assign secondary_reset_o = sec_rst_reg;
  assign upstream_reset_o  = up_rst_reg;

  // forwarding decision registered one cycle after the io request
  logic vga_fwd_next;
  assign vga_fwd_next = io_req_i & vga_en_reg & vga_hit;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      vga_fwd_reg <= 1'b0;
    else
      vga_fwd_reg <= vga_fwd_next;
  end
  assign vga_forward_o = vga_fwd_reg;
endmodule // switch_port_config_capability_regs
`default_nettype wire

// ### bench/port_cfg_properties.sv
`timescale 1ns/1ps
`default_nettype none
// watches the top ports only
module port_cfg_checker
(
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  input wire logic                     upstream_port_i,
  input wire logic                     wb_stb_i,
  input wire logic                     wb_we_i,
  input wire logic [7:0]               wb_adr_i,
  input wire port_cfg_pkg::cfg_word_t  wb_dat_o,
  input wire logic                     wb_ack_o,
  input wire logic                     io_req_i,
  input wire logic [15:0]              io_addr_i,
  input wire logic                     vga_forward_o,
  input wire logic                     secondary_reset_o,
  input wire logic                     upstream_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // read answers and the 10-bit vga window
  wire       rd = wb_ack_o && !wb_we_i;
  wire [9:0] lo = io_addr_i[9:0];
  wire       hit = (lo >= 10'h3b0 && lo <= 10'h3bb) || (lo >= 10'h3c0 && lo <= 10'h3df);
  property p_ack; $rose(wb_stb_i) |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late or long");
  property p_ack_req; wb_ack_o |-> wb_stb_i; endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack without request");
  property p_cap_id; rd && wb_adr_i == 8'h40 |-> wb_dat_o[7:0] == 8'h10 && !wb_dat_o[31]; endproperty
  a_cap_id: assert property (p_cap_id) else $error("bad capability id");
  property p_type; rd && wb_adr_i == 8'h40 |-> wb_dat_o[23:20] == (upstream_port_i ? 4'h5 : 4'h6); endproperty
  a_type: assert property (p_type) else $error("bad port type");
  property p_msg; rd && wb_adr_i == 8'h40 |-> wb_dat_o[29:25] == 5'h0 && !(upstream_port_i && wb_dat_o[24]); endproperty
  a_msg: assert property (p_msg) else $error("bad message or slot");
  property p_dcap; rd && wb_adr_i == 8'h44 |-> wb_dat_o[4:3] == 2'h0 && wb_dat_o[8:6] == 3'h0; endproperty
  a_dcap: assert property (p_dcap) else $error("read-only caps not zero");
  property p_bctl; rd && wb_adr_i == 8'h3c |-> (wb_dat_o[31:16] & 16'hffe7) == 16'h0; endproperty
  a_bctl: assert property (p_bctl) else $error("reserved bridge bits set");
  property p_fwd; vga_forward_o |-> $past(io_req_i) && $past(hit); endproperty
  a_fwd: assert property (p_fwd) else $error("forward without vga request");
  property p_rst; secondary_reset_o || upstream_reset_o |=> !secondary_reset_o && !upstream_reset_o; endproperty
  a_rst: assert property (p_rst) else $error("reset pulse too long");
  property p_side; (secondary_reset_o |-> !upstream_port_i) and (upstream_reset_o |-> upstream_port_i); endproperty
  a_side: assert property (p_side) else $error("reset on wrong port side");
endmodule // port_cfg_checker
`default_nettype wire

// ### bench/tb_switch_port_config_capability_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_switch_port_config_capability_regs;
  import port_cfg_pkg::*;
  logic        clk_i = 0, rst_i = 1, upstream_port_i = 0, mode_v11_i = 0;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, io_req_i = 0, lk;
  logic [7:0]  wb_adr_i = 0;
  cfg_sel_t    wb_sel_i = 0;
  cfg_word_t   wb_dat_i = 0, wb_dat_o, m40, m44, m3c, rd, w40;
  logic [15:0] io_addr_i = 0;
  logic        wb_ack_o, vga_forward_o, secondary_reset_o, upstream_reset_o;
  int          error_cnt = 0, n_compared = 0, cyc_n = 0, rs = 0, ru = 0, es[2] = '{0, 0};
  logic [15:0] tbl[9] = '{16'h03b0, 16'h03bb, 16'h03bc, 16'h03af, 16'h03c0, 16'h03df, 16'h03e0, 16'h0bc4, 16'hf3b5};
  always #50 clk_i = ~clk_i;
  switch_port_config_capability_regs uut
  (
    .clk_i(clk_i), .rst_i(rst_i), .upstream_port_i(upstream_port_i), .mode_v11_i(mode_v11_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .io_req_i(io_req_i), .io_addr_i(io_addr_i),
    .vga_forward_o(vga_forward_o), .secondary_reset_o(secondary_reset_o), .upstream_reset_o(upstream_reset_o)
  );
  // pulse counters and hang guard
  always @(posedge clk_i)
  begin
    rs += secondary_reset_o;
    ru += upstream_reset_o;
    if (++cyc_n > 20000)
    begin
      error_cnt++;
      stop_test;
    end
  end
  task stop_test;
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input cfg_word_t g, e);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // classic cycle: hold until ack, take data at that edge
  task bus(input logic w, input logic [7:0] a, input cfg_sel_t s, input cfg_word_t d);
    @(posedge clk_i);
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a; wb_sel_i <= s; wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  function cfg_word_t upd(cfg_word_t m, wm, cfg_sel_t s, cfg_word_t d);
    cfg_word_t l;
    l = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & wm;
    return (m & ~l) | (d & l);
  endfunction
  // write and update the model; lock only holds the lockable fields
  task wr(input logic [7:0] a, input cfg_sel_t s, input cfg_word_t d);
    bus(1, a, s, d);
    case (a)
      8'h40: if (!lk) m40 = upd(m40, w40, s, d);
      8'h44: if (!lk) m44 = upd(m44, 32'h27, s, d);
      8'h3c: begin m3c = upd(m3c, 32'h180000, s, d); es[upstream_port_i] += s[2] & d[22]; end
      8'h80: if (s[0]) lk = d[0];
      default: ;
    endcase
  endtask
  task rdc(input logic [7:0] a, input cfg_word_t e);
    bus(0, a, 4'hf, 0);
    chk(rd, e);
  endtask
  function logic inr(logic [15:0] x);
    return (x >= 16'h03b0 && x <= 16'h03bb) || (x >= 16'h03c0 && x <= 16'h03df);
  endfunction
  task io(input logic [15:0] a);
    @(posedge clk_i);
    io_req_i <= 1;
    io_addr_i <= a;
    @(posedge clk_i);
    io_req_i <= 0;
    @(posedge clk_i);
    chk(vga_forward_o, m3c[19] && (m3c[20] ? inr(a) : inr({6'h0, a[9:0]})));
  endtask
  initial
  begin
    void'($urandom(32'he71a089e));
    // downstream normal mode, then upstream in 1.1 mode
    for (int k = 0; k < 2; k++)
    begin
      rst_i <= 1; upstream_port_i <= k[0]; mode_v11_i <= k[0];
      repeat (10) @(posedge clk_i);
      rst_i <= 0;
      lk = 0; m3c = 0; m44 = 32'h24;
      m40 = {1'b0, !k[0], 6'h0, k[0] ? 4'h5 : 4'h6, 4'h1, 8'hc0, 8'h10};
      w40 = k[0] ? 32'h400fff00 : 32'h410fff00;
      repeat (2) @(posedge clk_i);
      rdc(8'h40, m40);
      rdc(8'h44, m44);
      rdc(8'h3c, m3c);
      repeat (12)
      begin
        wr(tbl[$urandom % 3][7:0] & 8'h00 | (8'h3c + 8'h4 * 8'($urandom % 3)) & 8'h7c, cfg_sel_t'($urandom), $urandom);
        rdc(8'h40, m40);
        rdc(8'h44, m44);
        rdc(8'h3c, m3c);
      end
      for (int c = 0; c < 4; c++)
      begin
        wr(8'h3c, 4'h4, {11'h0, c[1], c[0], 19'h0});
        foreach (tbl[i]) io(tbl[i]);
        io(16'($urandom));
      end
      wr(8'h80, 4'h1, 32'h1);
      wr(8'h40, 4'hf, $urandom);
      wr(8'h44, 4'hf, $urandom);
      rdc(8'h40, m40);
      rdc(8'h44, m44);
      wr(8'h80, 4'h1, 32'h0);
      wr(8'h10, 4'hf, $urandom);
      rdc(8'h10, 32'h0);
    end
    chk(rs, es[0]);
    chk(ru, es[1]);
    stop_test;
  end
endmodule // tb_switch_port_config_capability_regs
bind switch_port_config_capability_regs port_cfg_checker u_chk
(
  .clk_i(clk_i), .rst_i(rst_i), .upstream_port_i(upstream_port_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .io_req_i(io_req_i), .io_addr_i(io_addr_i),
  .vga_forward_o(vga_forward_o), .secondary_reset_o(secondary_reset_o), .upstream_reset_o(upstream_reset_o)
);
`default_nettype wire
